// ===== shared/rtc_map.svh
// Register offsets, field positions and timing counts of the clock configuration block.
// Functional notes
// - The enable bit and both value window halves accept writes only while the unlock bit is 1.
// - The configuration register returns to its reset state on power-on reset and nothing else.
// - The half-second flag is read-only and clears on a write of the low minutes/seconds half.
// - Bit 11 reads 0 in the first half of each second and 1 in the second half.
// - The clock output is driven only while the output enable in bit 10 is 1.
// - Bit 12 is set while a rollover can corrupt a value read; software reads twice to match.
// - Pointer 9:8: high 01 weekday, 10 month, 11 reserved; low 01 hours, 10 day, 11 year.
// - The pointer steps down by one on each access of the high window half and stops at 00.
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

`define RTC_CFG_ADR        8'h00
`define RTC_VAL_ADR        8'h04
`define RTC_EN_BIT         15
`define RTC_UNLOCK_BIT     13
`define RTC_SYNC_BIT       12
`define RTC_HALF_BIT       11
`define RTC_OE_BIT         10
`define RTC_PTR_LSB        8
`define RTC_CFG_RESET      16'h0000
`define RTC_CLK_KHZ        200000
`define RTC_HALF_SEC_MS    500
`define RTC_HALF_SEC_CYC   (`RTC_HALF_SEC_MS * `RTC_CLK_KHZ)
`define RTC_SYNC_LEAD      32
`define RTC_SEC_MAX        8'h3b
`define RTC_MIN_MAX        8'h3b

`endif

// ===== shared/rtc_pkg.sv
// Types shared by the clock configuration block.
`default_nettype none
package rtc_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } rtc_wb_req_t;

  typedef struct packed {
    logic       en;
    logic       rsv;
    logic       unlock;
    logic       sync;
    logic       half;
    logic       oe;
    logic [1:0] ptr;
    logic [7:0] cal;
  } rtc_cfg_t;

endpackage
`default_nettype wire

// ===== design/rtc_tick.sv
// Half-second phase divider with a one-cycle seconds tick and rollover warning.
`default_nettype none
module rtc_tick #(
  parameter int unsigned HALF_CYCLES = 100000000,
  parameter int unsigned SYNC_LEAD   = 32
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic run_i,
  input  wire logic clear_i,
  // Status
  output logic      half_o,
  output logic      tick_o,
  output logic      near_o
);
  localparam logic [31:0] LAST = 32'(2 * HALF_CYCLES - 1);

  logic [31:0] cnt;
  logic [31:0] next_cnt;

  always_comb
  begin
    next_cnt = cnt;
    if (clear_i)
      next_cnt = 32'h0;
    else if (run_i)
      next_cnt = (cnt == LAST) ? 32'h0 : cnt + 32'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= 32'h0;
    else
      cnt <= next_cnt;
  end

  // Phase and warning decode from the counter; the warning covers the last cycles before wrap.
  assign half_o = cnt >= 32'(HALF_CYCLES);
  assign tick_o = run_i && !clear_i && cnt == LAST;
  assign near_o = run_i && cnt >= 32'(2 * HALF_CYCLES - SYNC_LEAD);
endmodule
`default_nettype wire

// ===== design/rtc_top.sv
// Clock configuration register, value window and Wishbone slave of the calendar block.
`include "rtc_map.svh"
`default_nettype none
module rtc_top #(
  parameter int unsigned HALF_SEC_CYCLES = `RTC_HALF_SEC_CYC,
  parameter int unsigned SYNC_LEAD       = `RTC_SYNC_LEAD
) (
  // Clock and resets
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                soft_rst_i,
  // Wishbone slave
  input  wire rtc_pkg::rtc_wb_req_t wb_req_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  // Clock output pin
  output logic                     clk_out_o,
  output logic                     clk_out_oe_o
);
  import rtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  rtc_cfg_t    cfg;
  rtc_cfg_t    next_cfg;
  rtc_cfg_t    live_cfg;
  logic [7:0]  fld [0:7];
  logic [7:0]  next_fld [0:7];
  logic        next_ack;
  logic [31:0] next_rdat;
  logic        next_clk_out;
  logic        next_clk_oe;
  logic        clr_div;
  logic        half;
  logic        tick;
  logic        near;
  logic        req;

  // Field slot for a pointer value and window half; slot 7 is the reserved one.
  function automatic logic [2:0] slot(input logic [1:0] ptr, input logic hi);
    return {ptr, hi};
  endfunction

  rtc_tick #(
    .HALF_CYCLES (HALF_SEC_CYCLES),
    .SYNC_LEAD   (SYNC_LEAD)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (cfg.en),
    .clear_i (clr_div),
    .half_o  (half),
    .tick_o  (tick),
    .near_o  (near)
  );

  always_comb
  begin
    live_cfg      = cfg;
    live_cfg.rsv  = 1'b0;
    live_cfg.sync = near;
    live_cfg.half = half;
  end

  assign req = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb
  begin
    next_cfg  = cfg;
    next_fld  = fld;
    next_ack  = req;
    next_rdat = wb_dat_o;
    clr_div   = 1'b0;
    // Seconds and minutes advance on the tick; a software write below overrides.
    if (tick)
    begin
      if (fld[0] == `RTC_SEC_MAX)
      begin
        next_fld[0] = 8'h00;
        next_fld[1] = (fld[1] == `RTC_MIN_MAX) ? 8'h00 : fld[1] + 8'h01;
      end
      else
        next_fld[0] = fld[0] + 8'h01;
    end
    if (req)
    begin
      case (wb_req_i.adr)
        `RTC_CFG_ADR:
        begin
          next_rdat = {16'h0000, live_cfg};
          if (wb_req_i.we && wb_req_i.sel[1])
          begin
            if (cfg.unlock)
              next_cfg.en = wb_req_i.dat[`RTC_EN_BIT];
            next_cfg.unlock = wb_req_i.dat[`RTC_UNLOCK_BIT];
            next_cfg.oe     = wb_req_i.dat[`RTC_OE_BIT];
            next_cfg.ptr    = wb_req_i.dat[`RTC_PTR_LSB +: 2];
          end
          if (wb_req_i.we && wb_req_i.sel[0])
            next_cfg.cal = wb_req_i.dat[7:0];
        end
        `RTC_VAL_ADR:
        begin
          next_rdat = {16'h0000, fld[slot(cfg.ptr, 1'b1)], fld[slot(cfg.ptr, 1'b0)]};
          if (wb_req_i.we && cfg.unlock)
          begin
            if (wb_req_i.sel[1] && cfg.ptr != 2'b11)
              next_fld[slot(cfg.ptr, 1'b1)] = wb_req_i.dat[15:8];
            if (wb_req_i.sel[0])
              next_fld[slot(cfg.ptr, 1'b0)] = wb_req_i.dat[7:0];
            if (wb_req_i.sel[0] && cfg.ptr == 2'b00)
              clr_div = 1'b1;
          end
          if (wb_req_i.sel[1] && cfg.ptr != 2'b00)
            next_cfg.ptr = cfg.ptr - 2'b01;
        end
        default:
          next_rdat = 32'h0000_0000;
      endcase
    end
    next_clk_oe  = cfg.oe;
    next_clk_out = cfg.oe && half;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers. Only rst_i, the power-on reset, touches the configuration.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg          <= `RTC_CFG_RESET;
      fld          <= '{default: 8'h00};
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
      clk_out_o    <= 1'b0;
      clk_out_oe_o <= 1'b0;
    end
    else
    begin
      cfg          <= next_cfg;
      fld          <= next_fld;
      wb_ack_o     <= next_ack && !soft_rst_i;
      wb_dat_o     <= next_rdat;
      clk_out_o    <= next_clk_out;
      clk_out_oe_o <= next_clk_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic        wr_cfg_hi;
  logic        acc_val_hi;
  logic [63:0] fld_flat;
  assign wr_cfg_hi  = req && wb_req_i.we && wb_req_i.adr == `RTC_CFG_ADR && wb_req_i.sel[1];
  assign acc_val_hi = req && wb_req_i.adr == `RTC_VAL_ADR && wb_req_i.sel[1];

  // Flat copy of the field store so that the checks can sample it as one vector.
  for (genvar g = 0; g < 8; g++)
  begin : g_fld_flat
    assign fld_flat[8*g +: 8] = fld[g];
  end

  AST_EN_LOCKED: assert property (wr_cfg_hi && !cfg.unlock |=> $stable(cfg.en))
    else $error("Enable changed while unlock was clear.");
  AST_VAL_LOCKED: assert property (req && wb_req_i.we && wb_req_i.adr == `RTC_VAL_ADR
      && !cfg.unlock && !tick |=> fld_flat == $past(fld_flat))
    else $error("Value field written while unlock was clear.");
  AST_SOFT_KEEPS: assert property (soft_rst_i && !req |=> cfg == $past(cfg))
    else $error("Configuration changed on a non power-on reset.");
  AST_HALF_CLR: assert property (clr_div |=> !live_cfg.half)
    else $error("Half-second flag not cleared by seconds write.");
  AST_HALF_PHASE: assert property ($rose(half) && !clr_div |=> half [*3])
    else $error("Half-second flag did not hold its phase.");
  AST_OE_OFF: assert property (!cfg.oe |=> !clk_out_oe_o && !clk_out_o)
    else $error("Clock output driven with output enable clear.");
  AST_SYNC_BEFORE_TICK: assert property (tick |-> live_cfg.sync)
    else $error("Rollover occurred without the sync flag set.");
  AST_PTR_STEP: assert property (acc_val_hi && cfg.ptr != 2'b00 |=>
      cfg.ptr == $past(cfg.ptr) - 2'b01 ##1 wb_ack_o == 1'b0)
    else $error("Window pointer did not step down.");
  AST_PTR_FLOOR: assert property (acc_val_hi && cfg.ptr == 2'b00 |=> cfg.ptr == 2'b00)
    else $error("Window pointer stepped below zero.");
  AST_READ_MAP: assert property (req && !wb_req_i.we && wb_req_i.adr == `RTC_VAL_ADR
      && cfg.ptr == 2'b11 |=> wb_ack_o && wb_dat_o[15:8] == 8'h00)
    else $error("Reserved window field did not read as zero.");

  COV_UNLOCK_EN: cover property (wr_cfg_hi && cfg.unlock ##1 cfg.en);
  COV_PTR_WALK: cover property (acc_val_hi && cfg.ptr == 2'b11 ##3 acc_val_hi ##3 acc_val_hi);
  COV_TICK: cover property (tick);
  COV_CLK_OUT: cover property ($rose(clk_out_o));
endmodule
`default_nettype wire

// ===== tb/tb_rtc_top.sv
// Self-checking bench for the clock configuration block.
`default_nettype none
module tb_rtc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;

  logic                 clk_i;
  logic                 rst_i;
  logic                 soft_rst_i;
  rtc_wb_req_t          req;
  logic        [31:0]   wb_dat_o;
  logic                 wb_ack_o;
  logic                 clk_out_o;
  logic                 clk_out_oe_o;
  logic        [31:0]   rd;
  logic        [15:0]   vals [4] = '{16'h5566, 16'h7788, 16'h99aa, 16'h3b2c};
  logic        [31:0]   exps [5] = '{32'h66, 32'h7788, 32'h99aa, 32'h3b2c, 32'h3b2c};
  int                   err_total = 0;
  int                   n_tests = 0;
  int                   cyc_cnt = 0;
  int                   hits;
  int                   halfs;

  rtc_top #(.HALF_SEC_CYCLES(8), .SYNC_LEAD(2)) dut (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .soft_rst_i   (soft_rst_i),
    .wb_req_i     (req),
    .wb_dat_o     (wb_dat_o),
    .wb_ack_o     (wb_ack_o),
    .clk_out_o    (clk_out_o),
    .clk_out_oe_o (clk_out_oe_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 2000)
    begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One classic cycle; entered just after a rising edge, leaves one idle cycle.
  task automatic wb(input logic [7:0] adr, input logic we, input logic [1:0] sel,
                    input logic [15:0] dat, output logic [31:0] q);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: {2'b00, sel}, adr: adr, dat: {16'h0, dat}};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [1:0] sel, input logic [15:0] dat);
    logic [31:0] q;
    wb(adr, 1'b1, sel, dat, q);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    wb(adr, 1'b0, 2'b11, 16'h0, rd);
    chk(name, exp, rd);
  endtask

  task automatic count_out(input int n);
    halfs = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      halfs += (clk_out_o === 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_i = 1'b1;
    soft_rst_i = 1'b0;
    req = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("cfg_reset", 8'h00, 32'h0);
    chk("oe_reset", 32'h0, {31'h0, clk_out_oe_o});
    wr(8'h00, 2'b11, 16'h80ab);
    rd_chk("cfg_locked_en", 8'h00, 32'h00ab);
    wr(8'h04, 2'b01, 16'h0012);
    rd_chk("sec_locked", 8'h04, 32'h0);
    wr(8'h00, 2'b11, 16'h7bcd);
    rd_chk("cfg_ro_bits", 8'h00, 32'h23cd);
    for (int i = 0; i < 4; i++)
      wr(8'h04, 2'b11, vals[i]);
    wr(8'h00, 2'b11, 16'h2300);
    for (int i = 0; i < 5; i++)
      rd_chk("window", 8'h04, exps[i]);
    rd_chk("ptr_floor", 8'h00, 32'h2000);
    wr(8'h00, 2'b11, 16'h2200);
    wb(8'h04, 1'b0, 2'b01, 16'h0, rd);
    soft_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    soft_rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("cfg_soft_rst", 8'h00, 32'h2200);
    rd_chk("unmapped", 8'h08, 32'h0);
    wr(8'h00, 2'b11, 16'h2400);
    wr(8'h00, 2'b11, 16'ha400);
    wr(8'h04, 2'b01, 16'h0000);
    rd_chk("half_cleared", 8'h00, 32'ha400);
    hits = 0;
    halfs = 0;
    for (int i = 0; i < 16; i++)
    begin
      wb(8'h00, 1'b0, 2'b11, 16'h0, rd);
      hits += (rd[12] === 1'b1);
      halfs += (rd[11] === 1'b1);
    end
    chk("sync_hits", 32'h2, hits);
    chk("half_hits", 32'h8, halfs);
    chk("oe_on", 32'h1, {31'h0, clk_out_oe_o});
    count_out(32);
    chk("out_highs", 32'h10, halfs);
    wr(8'h00, 2'b11, 16'ha000);
    count_out(16);
    chk("out_off", 32'h0, halfs);
    chk("oe_off", 32'h0, {31'h0, clk_out_oe_o});
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("cfg_por", 8'h00, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
